// [inc/efb_defs.svh]
// Constants for the external code fetch bus block
`ifndef EFB_DEFS_SVH
`define EFB_DEFS_SVH

// Address map of the code space
`define EFB_RESET_ADDR      24'hff0000
`define EFB_TOP_SEG         8'hff
`define EFB_SEG_LAST        16'hffff
`define EFB_INT_SIZE        32768
`define EFB_INT_AW          15
`define EFB_INT_LAST        16'h7fff
`define EFB_INT_TAIL_BASE   16'h7ff8

// Stall control register in the special register space
`define EFB_STALL_CTRL_ADDR  8'ha7
`define EFB_STALL_CTRL_RESET 2'h0
`define EFB_LIVE_STALL_BIT   0
`define EFB_STALL_CLK_BIT    1

// Bus cycle timing in oscillator cycles
`define EFB_STRB_CYCLES     2'h2
`define EFB_STRAP_SETTLE    2'h3

`endif

// [inc/efb_pkg.sv]
// Types shared by the external code fetch bus block
package efb_pkg;

  // Bus sequencer states
  typedef enum logic [2:0] {
    EFB_IDLE = 3'b000,
    EFB_INT  = 3'b001,
    EFB_ADDR = 3'b010,
    EFB_STRB = 3'b011,
    EFB_DONE = 3'b100
  } efb_state_t;

  // Kind of access in progress
  typedef enum logic [1:0] {
    EFB_K_FETCH = 2'b00,
    EFB_K_CONST = 2'b01,
    EFB_K_READ  = 2'b10,
    EFB_K_WRITE = 2'b11
  } efb_kind_t;

endpackage : efb_pkg

// [verilog/efb_sync.sv]
// Two-flop synchroniser for the pin inputs of the fetch bus
`timescale 1ns/1ps
module efb_sync (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Asynchronous pins and their synchronised copies
  input  wire logic [9:0]  pins,
  output logic      [9:0]  pins_sync
);
  import efb_pkg::*;

  logic [9:0] meta_r;
  logic [9:0] meta_nxt;
  logic [9:0] sync_r;
  logic [9:0] sync_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // First stage is read only by the second; idle level high (pins pulled up)
  always_comb begin
    meta_nxt = pins;
    sync_nxt = meta_r;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 10'h3ff;
      sync_r <= 10'h3ff;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign pins_sync = sync_r;

endmodule : efb_sync

// [verilog/efb_sfr.sv]
// Stall control register in the special register space, bit addressable
`timescale 1ns/1ps
`include "efb_defs.svh"
module efb_sfr (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Special register port of the core
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_bit_wr,
  input  wire logic [2:0]  sfr_bit_sel,
  input  wire logic        sfr_bit_val,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  // Control bits
  output logic             live_stall_enable,
  output logic             stall_clock_enable
);
  import efb_pkg::*;

  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       sel;

  assign sel     = (sfr_addr == `EFB_STALL_CTRL_ADDR); // R13
  assign sfr_hit = sel;

  ////////////////////////////////////////////////////////////////////////////
  // Byte write, single-bit write and registered read; upper bits read zero
  always_comb begin
    ctrl_nxt  = ctrl_r;
    rdata_nxt = rdata_r;
    if (sel && sfr_wr) begin
      ctrl_nxt = sfr_wdata[1:0];
    end else if (sel && sfr_bit_wr && (sfr_bit_sel[2:1] == 2'h0)) begin
      ctrl_nxt[sfr_bit_sel[0]] = sfr_bit_val; // R13
    end
    if (sel && sfr_rd) begin
      rdata_nxt = {6'h00, ctrl_r};
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r  <= `EFB_STALL_CTRL_RESET;
      rdata_r <= 8'h00;
    end else begin
      ctrl_r  <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign sfr_rdata          = rdata_r;
  assign live_stall_enable  = ctrl_r[`EFB_LIVE_STALL_BIT];
  assign stall_clock_enable = ctrl_r[`EFB_STALL_CLK_BIT];

endmodule : efb_sfr

// [verilog/efb_fetch_bus.sv]
// Code fetch router between internal code memory and the external bus
`timescale 1ns/1ps
`include "efb_defs.svh"
//
// Contract
// [R1] With the strap high, top-segment addresses below 8000h come from the 32 KB internal memory.
// [R2] With the strap low, every code access runs as an external bus cycle.
// [R3] A part without internal code memory must have its strap tied low.
// [R4] Fetching starts at FF:0000h after reset and wraps there past the segment end.
// [R5] Prefetch past FF:7FFFh from the last eight internal bytes goes out on the bus.
// [R6] Constant reads from the last eight internal bytes cause no bus activity.
// [R7] The ready input counts only while its enable bit at A7h is set.
// [R8] External memory drives the ready input during bus cycles.
// [R9] A low ready level stretches the cycle by whole wait states until it goes high.
// [R10] When enabled, the stall clock output toggles at half the oscillator rate.
// [R11] External writes drive an active-low write strobe.
// [R12] All timing is derived from the oscillator input.
// [R13] The stall control register sits in the bit-addressable special register space.
module efb_fetch_bus (
  // Oscillator clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Straps and pins from outside
  input  wire logic        code_source_select,
  input  wire logic        bus_ready_n,
  // Instruction fetch port of the core
  input  wire logic        fetch_req,
  input  wire logic        fetch_jump,
  input  wire logic [23:0] jump_addr,
  output logic             fetch_ack,
  output logic      [7:0]  fetch_data,
  output logic      [23:0] fetch_pc,
  // Data and constant port of the core
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_code,
  input  wire logic [23:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_ack,
  output logic      [7:0]  mem_rdata,
  // Loading port of the internal code memory
  input  wire logic        code_load_we,
  input  wire logic [14:0] code_load_addr,
  input  wire logic [7:0]  code_load_data,
  // Special register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_bit_wr,
  input  wire logic [2:0]  sfr_bit_sel,
  input  wire logic        sfr_bit_val,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  // External bus pins
  input  wire logic [7:0]  low_bus_port_pin,
  output logic      [7:0]  low_bus_port_data,
  output logic             low_bus_port_oe,
  output logic      [7:0]  high_bus_port_data,
  output logic             high_bus_port_oe,
  output logic      [7:0]  bus_segment,
  output logic             addr_latch,
  output logic             code_strobe_n,
  output logic             read_n,
  output logic             write_n,
  output logic             stall_clock,
  // Status
  output logic             internal_code
);
  import efb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]  code_mem [0:`EFB_INT_SIZE-1];
  logic [7:0]  rom_q;
  logic [9:0]  pins_sync;
  logic        strap_s;
  logic        ready_s_n;
  logic [7:0]  rdpin_s;
  logic        live_en;
  logic        clk_en;

  efb_state_t  state_r,   state_nxt;
  efb_kind_t   kind_r,    kind_nxt;
  logic [23:0] addr_r,    addr_nxt;
  logic [7:0]  wdata_r,   wdata_nxt;
  logic [1:0]  cnt_r,     cnt_nxt;
  logic [23:0] pc_r,      pc_nxt;
  logic        fack_r,    fack_nxt;
  logic        mack_r,    mack_nxt;
  logic [7:0]  fdata_r,   fdata_nxt;
  logic [7:0]  mdata_r,   mdata_nxt;
  logic [1:0]  settle_r,  settle_nxt;
  logic        strap_r,   strap_nxt;
  logic        ale_r,     ale_nxt;
  logic        psen_r,    psen_nxt;
  logic        rd_r,      rd_nxt;
  logic        wr_r,      wr_nxt;
  logic [7:0]  lo_r,      lo_nxt;
  logic        lo_oe_r,   lo_oe_nxt;
  logic [7:0]  hi_r,      hi_nxt;
  logic        hi_oe_r,   hi_oe_nxt;
  logic [7:0]  seg_r,     seg_nxt;
  logic        wclk_r,    wclk_nxt;
  logic        in_int;
  logic        ext_done;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and the stall control register
  efb_sync u_sync (
    .mclk      (mclk),
    .resetn    (resetn),
    .pins      ({low_bus_port_pin, bus_ready_n, code_source_select}),
    .pins_sync (pins_sync)
  );

  assign strap_s   = pins_sync[0];
  assign ready_s_n = pins_sync[1];
  assign rdpin_s   = pins_sync[9:2];

  efb_sfr u_sfr (
    .mclk               (mclk),
    .resetn             (resetn),
    .sfr_addr           (sfr_addr),
    .sfr_wr             (sfr_wr),
    .sfr_wdata          (sfr_wdata),
    .sfr_bit_wr         (sfr_bit_wr),
    .sfr_bit_sel        (sfr_bit_sel),
    .sfr_bit_val        (sfr_bit_val),
    .sfr_rd             (sfr_rd),
    .sfr_rdata          (sfr_rdata),
    .sfr_hit            (sfr_hit),
    .live_stall_enable  (live_en),
    .stall_clock_enable (clk_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Internal code memory; no reset so it maps onto a plain array
  always_ff @(posedge mclk) begin
    if (code_load_we) begin
      code_mem[code_load_addr] <= code_load_data;
    end
    rom_q <= code_mem[addr_r[`EFB_INT_AW-1:0]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing decision for an address; a prefetch past 7FFFh misses and goes out
  function automatic logic int_hit(input logic strap, input logic [23:0] a);
    int_hit = strap && (a[23:16] == `EFB_TOP_SEG) && (a[15:0] <= `EFB_INT_LAST); // R1 R2 R5
  endfunction : int_hit

  assign in_int   = int_hit(strap_r, addr_r);
  // Synced pin read directly; an extra register would see ready only after the strobe
  assign ext_done = (cnt_r == (`EFB_STRB_CYCLES - 2'h1)) && !(live_en && !ready_s_n);

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture after the synchroniser settles, then held until reset
  always_comb begin
    settle_nxt = settle_r;
    strap_nxt  = strap_r;
    if (settle_r != `EFB_STRAP_SETTLE) begin
      settle_nxt = settle_r + 2'h1;
      strap_nxt  = strap_s; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stall clock: one toggle per oscillator cycle gives half the rate
  always_comb begin
    wclk_nxt = clk_en ? !wclk_r : 1'b0; // R10 R12
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencer, fetch counter and registered pin values
  always_comb begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    cnt_nxt   = cnt_r;
    pc_nxt    = pc_r;
    fack_nxt  = 1'b0;
    mack_nxt  = 1'b0;
    fdata_nxt = fdata_r;
    mdata_nxt = mdata_r;
    if (fetch_jump) begin
      pc_nxt = jump_addr;
    end
    unique case (state_r)
      EFB_IDLE: begin
        // Data side first; requests wait until the strap is known
        if ((settle_r == `EFB_STRAP_SETTLE) && mem_req && !mack_r) begin
          addr_nxt  = mem_addr;
          wdata_nxt = mem_wdata;
          kind_nxt  = mem_we ? EFB_K_WRITE : (mem_code ? EFB_K_CONST : EFB_K_READ);
          // Constant reads in internal range never leave the chip
          if (!mem_we && mem_code && int_hit(strap_r, mem_addr)) begin
            state_nxt = EFB_INT; // R6
          end else begin
            state_nxt = EFB_ADDR;
          end
        end else if ((settle_r == `EFB_STRAP_SETTLE) && fetch_req && !fetch_jump
                     && !fack_r) begin
          addr_nxt  = pc_r;
          kind_nxt  = EFB_K_FETCH;
          state_nxt = int_hit(strap_r, pc_r) ? EFB_INT : EFB_ADDR; // R1 R2 R5
        end
      end
      EFB_INT: begin
        state_nxt = EFB_DONE;
      end
      EFB_ADDR: begin
        cnt_nxt   = 2'h0;
        state_nxt = EFB_STRB;
      end
      EFB_STRB: begin
        // Ready low stretches by whole cycles only while enabled
        if (ext_done) begin
          state_nxt = EFB_DONE; // R7 R9
        end else if (cnt_r != (`EFB_STRB_CYCLES - 2'h1)) begin
          cnt_nxt = cnt_r + 2'h1;
        end
      end
      EFB_DONE: begin
        state_nxt = EFB_IDLE;
        if (kind_r == EFB_K_FETCH) begin
          fack_nxt  = 1'b1;
          fdata_nxt = in_int ? rom_q : rdpin_s;
          if (!fetch_jump) begin
            // Wrap inside the top segment back to the reset address
            if ((pc_r[23:16] == `EFB_TOP_SEG) && (pc_r[15:0] == `EFB_SEG_LAST)) begin
              pc_nxt = `EFB_RESET_ADDR; // R4
            end else begin
              pc_nxt = pc_r + 24'h000001;
            end
          end
        end else begin
          mack_nxt  = 1'b1;
          mdata_nxt = (kind_r == EFB_K_WRITE) ? mdata_r : (in_int ? rom_q : rdpin_s);
        end
      end
      default: begin
        state_nxt = EFB_IDLE;
      end
    endcase
    // Pins follow the next state so they come straight from flip-flops
    ale_nxt   = (state_nxt == EFB_ADDR);
    psen_nxt  = !((state_nxt == EFB_STRB) && (kind_nxt inside {EFB_K_FETCH, EFB_K_CONST}));
    rd_nxt    = !((state_nxt == EFB_STRB) && (kind_nxt == EFB_K_READ));
    wr_nxt    = !((state_nxt == EFB_STRB) && (kind_nxt == EFB_K_WRITE)); // R11
    hi_oe_nxt = (state_nxt == EFB_ADDR) || (state_nxt == EFB_STRB);
    hi_nxt    = hi_oe_nxt ? addr_nxt[15:8] : hi_r;
    seg_nxt   = hi_oe_nxt ? addr_nxt[23:16] : seg_r;
    // Low port carries address, then write data; released for reads
    lo_oe_nxt = (state_nxt == EFB_ADDR)
                || ((state_nxt == EFB_STRB) && (kind_nxt == EFB_K_WRITE));
    lo_nxt    = (state_nxt == EFB_ADDR) ? addr_nxt[7:0]
              : ((state_nxt == EFB_STRB) ? wdata_nxt : lo_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // All state registers on the oscillator clock
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r  <= EFB_IDLE;
      kind_r   <= EFB_K_FETCH;
      addr_r   <= `EFB_RESET_ADDR;
      wdata_r  <= 8'h00;
      cnt_r    <= 2'h0;
      pc_r     <= `EFB_RESET_ADDR; // R4
      fack_r   <= 1'b0;
      mack_r   <= 1'b0;
      fdata_r  <= 8'h00;
      mdata_r  <= 8'h00;
      settle_r <= 2'h0;
      strap_r  <= 1'b0;
      ale_r    <= 1'b0;
      psen_r   <= 1'b1;
      rd_r     <= 1'b1;
      wr_r     <= 1'b1;
      lo_r     <= 8'h00;
      lo_oe_r  <= 1'b0;
      hi_r     <= 8'h00;
      hi_oe_r  <= 1'b0;
      seg_r    <= 8'h00;
      wclk_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      kind_r   <= kind_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      cnt_r    <= cnt_nxt;
      pc_r     <= pc_nxt;
      fack_r   <= fack_nxt;
      mack_r   <= mack_nxt;
      fdata_r  <= fdata_nxt;
      mdata_r  <= mdata_nxt;
      settle_r <= settle_nxt;
      strap_r  <= strap_nxt;
      ale_r    <= ale_nxt;
      psen_r   <= psen_nxt;
      rd_r     <= rd_nxt;
      wr_r     <= wr_nxt;
      lo_r     <= lo_nxt;
      lo_oe_r  <= lo_oe_nxt;
      hi_r     <= hi_nxt;
      hi_oe_r  <= hi_oe_nxt;
      seg_r    <= seg_nxt;
      wclk_r   <= wclk_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign fetch_ack          = fack_r;
  assign fetch_data         = fdata_r;
  assign fetch_pc           = pc_r;
  assign mem_ack            = mack_r;
  assign mem_rdata          = mdata_r;
  assign low_bus_port_data  = lo_r;
  assign low_bus_port_oe    = lo_oe_r;
  assign high_bus_port_data = hi_r;
  assign high_bus_port_oe   = hi_oe_r;
  assign bus_segment        = seg_r;
  assign addr_latch         = ale_r;
  assign code_strobe_n      = psen_r;
  assign read_n             = rd_r;
  assign write_n            = wr_r;
  assign stall_clock        = wclk_r;
  assign internal_code      = strap_r;

endmodule : efb_fetch_bus

// [testbench/efb_fetch_bus_checker.sv]
// Checker of the fetch bus router ports
`timescale 1ns/1ps
`include "efb_defs.svh"
module efb_fetch_bus_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // Core and register side
  input wire logic        fetch_ack,
  input wire logic [23:0] fetch_pc,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        sfr_bit_wr,
  input wire logic [2:0]  sfr_bit_sel,
  input wire logic        sfr_bit_val,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  input wire logic        internal_code,
  // Bus pins
  input wire logic        bus_ready_n,
  input wire logic        low_bus_port_oe,
  input wire logic        high_bus_port_oe,
  input wire logic [7:0]  high_bus_port_data,
  input wire logic [7:0]  bus_segment,
  input wire logic        addr_latch,
  input wire logic        code_strobe_n,
  input wire logic        read_n,
  input wire logic        write_n,
  input wire logic        stall_clock
);
  logic [1:0] ctl_r;
  logic [1:0] ctl_nxt;
  logic       hit;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // Shadow of the two stall control bits, own decode so a bad hit shows
  assign hit = (sfr_addr == `EFB_STALL_CTRL_ADDR);
  always_comb begin
    ctl_nxt = ctl_r;
    if (sfr_wr && hit) ctl_nxt = sfr_wdata[1:0];
    if (sfr_bit_wr && hit && sfr_bit_sel < 3'h2) ctl_nxt[sfr_bit_sel[0]] = sfr_bit_val;
  end
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn) ctl_r <= 2'h0;
    else ctl_r <= ctl_nxt;
  ////////////////////////////////////////////////////////////
  // Properties
  AST_PC_STEP: assert property (fetch_ack |-> fetch_pc ==
    (($past(fetch_pc) == 24'hffffff) ? 24'hff0000 : $past(fetch_pc) + 24'h1))
    else $error("fetch counter step wrong");
  AST_INT_QUIET: assert property (!code_strobe_n && internal_code |->
    !(bus_segment == 8'hff && !high_bus_port_data[7])) else $error("internal code went out");
  AST_EXT_ALL: assert property (fetch_ack && !internal_code |->
    $past(code_strobe_n, 2) == 1'b0) else $error("fetch without bus cycle");
  AST_NO_STALL: assert property ($fell(code_strobe_n) && !ctl_r[0] |->
    ##2 code_strobe_n) else $error("stretch while ready disabled");
  AST_STRETCH: assert property (!bus_ready_n [*4] ##0 (!code_strobe_n && ctl_r[0])
    |=> !code_strobe_n) else $error("strobe ended while not ready");
  AST_RELEASE: assert property ($rose(bus_ready_n) && !code_strobe_n |->
    ##[1:5] code_strobe_n) else $error("strobe hangs after ready");
  AST_CLK_RUN: assert property (ctl_r[1] && $past(ctl_r[1]) |->
    stall_clock != $past(stall_clock)) else $error("stall clock not toggling");
  AST_CLK_IDLE: assert property (!ctl_r[1] && !$past(ctl_r[1]) |-> !stall_clock)
    else $error("stall clock runs while disabled");
  AST_WR_STROBE: assert property ($fell(write_n) |-> $past(addr_latch) &&
    low_bus_port_oe && code_strobe_n && read_n) else $error("bad write strobe");
  AST_ALE: assert property (addr_latch |-> low_bus_port_oe && high_bus_port_oe
    ##1 !addr_latch) else $error("bad address phase");
  AST_SFR_HIT: assert property (sfr_hit == hit)
    else $error("register decode wrong");
  AST_SFR_READ: assert property (sfr_rd && hit && !sfr_wr && !sfr_bit_wr |=>
    sfr_rdata == {6'h0, $past(ctl_r)}) else $error("register read wrong");
  // Main scenarios reached
  COV_EXT: cover property (fetch_ack && !internal_code);
  COV_WAIT: cover property (!bus_ready_n [*4] ##0 !code_strobe_n);
  COV_WRITE: cover property ($fell(write_n));
endmodule : efb_fetch_bus_checker

bind efb_fetch_bus efb_fetch_bus_checker chk (.*);

// [testbench/efb_ext_mem.sv]
// Behavioural external program and data memory on the multiplexed bus
`timescale 1ns/1ps
module efb_ext_mem (
  // Clock
  input wire logic        mclk,
  // Bus pins from the block
  input wire logic [7:0]  low_bus_port_data,
  input wire logic        low_bus_port_oe,
  input wire logic [7:0]  high_bus_port_data,
  input wire logic [7:0]  bus_segment,
  input wire logic        addr_latch,
  input wire logic        code_strobe_n,
  input wire logic        read_n,
  input wire logic        write_n,
  // Wait cycles to insert, wires back and last write seen
  input wire logic [3:0]  stall_len,
  output logic     [7:0]  low_bus_port_pin,
  output logic            bus_ready_n,
  output logic     [23:0] wr_addr,
  output logic     [7:0]  wr_data
);
  logic [23:0] addr_q = 24'h0;
  logic [3:0]  cnt = 4'h0;
  logic        rd;
  // Array pattern, a mix of all address bytes
  function automatic logic [7:0] ext_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
  endfunction : ext_byte
  // Wire level: block wins while driving, else data or its inverse once released
  assign rd = !code_strobe_n || !read_n;
  assign low_bus_port_pin = low_bus_port_oe ? low_bus_port_data :
                            rd ? ext_byte(addr_q) : ~ext_byte(addr_q);
  // Ready is pulled up, held low for the first stall_len cycles from address phase
  assign bus_ready_n = !(rd || !write_n || addr_latch) || cnt >= stall_len;
  // Address capture, write capture, wait counting
  always @(posedge mclk) begin
    if (addr_latch) addr_q <= {bus_segment, high_bus_port_data, low_bus_port_data};
    if (!write_n) begin
      wr_addr <= addr_q;
      wr_data <= low_bus_port_data;
    end
    cnt <= (rd || !write_n || addr_latch) ? cnt + 4'h1 : 4'h0;
  end
endmodule : efb_ext_mem

// [testbench/tb_efb_fetch_bus.sv]
// Self-checking bench of the fetch bus router
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, (e), (g)); end end
module tb_efb_fetch_bus;
  import efb_pkg::*;
  logic        mclk = 1'b0;
  logic        resetn, code_source_select, bus_ready_n, fetch_req, fetch_jump, fetch_ack;
  logic        mem_req, mem_we, mem_code, mem_ack, code_load_we, sfr_wr, sfr_bit_wr;
  logic        sfr_bit_val, sfr_rd, sfr_hit, low_bus_port_oe, high_bus_port_oe, v;
  logic        addr_latch, code_strobe_n, read_n, write_n, stall_clock, internal_code;
  logic [2:0]  sfr_bit_sel;
  logic [3:0]  stall_len;
  logic [7:0]  fetch_data, mem_wdata, mem_rdata, code_load_data, sfr_addr, sfr_wdata;
  logic [7:0]  sfr_rdata, low_bus_port_pin, low_bus_port_data, high_bus_port_data;
  logic [7:0]  bus_segment, d, wr_data;
  logic [14:0] code_load_addr;
  logic [23:0] jump_addr, fetch_pc, mem_addr, wr_addr;
  int          err_total = 0, check_count = 0, latch_cnt = 0, lat, c0, i;

  efb_fetch_bus dut (.*);

  efb_ext_mem mem (.mclk(mclk), .low_bus_port_data(low_bus_port_data),
    .low_bus_port_oe(low_bus_port_oe), .high_bus_port_data(high_bus_port_data),
    .bus_segment(bus_segment), .addr_latch(addr_latch), .code_strobe_n(code_strobe_n),
    .read_n(read_n), .write_n(write_n), .stall_len(stall_len),
    .low_bus_port_pin(low_bus_port_pin), .bus_ready_n(bus_ready_n), .wr_addr(wr_addr),
    .wr_data(wr_data));

  ////////////////////////////////////////////////////////////
  // Clock and address phase count, the latter tells internal from external
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (addr_latch === 1'b1) latch_cnt++;

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic do_reset(input logic strap);
    resetn = 1'b0;
    code_source_select = strap;
    repeat (8) tick();
    resetn = 1'b1;
    repeat (3) tick();
  endtask : do_reset

  // Byte write or single bit write of the stall control register
  task automatic sfr_put(input logic bit_mode, input logic [2:0] sel, input logic [7:0] w);
    sfr_addr = 8'ha7;
    sfr_wdata = w;
    sfr_bit_sel = sel;
    sfr_bit_val = w[0];
    sfr_wr = !bit_mode;
    sfr_bit_wr = bit_mode;
    tick();
    sfr_wr = 1'b0;
    sfr_bit_wr = 1'b0;
  endtask : sfr_put

  task automatic sfr_get(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick();
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : sfr_get

  // One access held until its ack; the wait is bounded
  task automatic acc(input efb_kind_t k, input logic [23:0] a, input logic [7:0] w);
    tick();
    fetch_req = (k == EFB_K_FETCH);
    mem_req = (k != EFB_K_FETCH);
    mem_we = (k == EFB_K_WRITE);
    mem_code = (k == EFB_K_CONST);
    mem_addr = a;
    mem_wdata = w;
    for (lat = 1; lat < 40; lat++) begin
      tick();
      if (fetch_ack === 1'b1 || mem_ack === 1'b1) break;
    end
    fetch_req = 1'b0;
    mem_req = 1'b0;
    d = (k == EFB_K_FETCH) ? fetch_data : mem_rdata;
    if (lat == 40) begin
      err_total++;
      print_verdict();
    end
  endtask : acc

  task automatic jump(input logic [23:0] a);
    tick();
    jump_addr = a;
    fetch_jump = 1'b1;
    tick();
    fetch_jump = 1'b0;
  endtask : jump

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {resetn, code_source_select, fetch_req, fetch_jump, mem_req, mem_we, mem_code} = '0;
    {code_load_we, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, sfr_bit_sel, stall_len} = '0;
    {jump_addr, mem_addr, mem_wdata, code_load_addr, code_load_data, sfr_wdata} = '0;
    sfr_addr = 8'ha7;
    do_reset(1'b0);
    sfr_get(8'ha7);
    `CHK("ctl reset", 8'h00, d)
    sfr_put(1'b0, 3'h0, 8'hff);
    sfr_get(8'ha7);
    `CHK("ctl byte", 8'h03, d)
    sfr_put(1'b1, 3'h0, 8'h0);
    sfr_put(1'b1, 3'h1, 8'h0);
    sfr_put(1'b1, 3'h5, 8'h1);
    sfr_get(8'ha7);
    `CHK("ctl bits", 8'h00, d)
    sfr_get(8'ha6);
    `CHK("unmapped hit", 1'b0, sfr_hit)
    $display("test register done");
    // Strap low: all code goes out
    c0 = latch_cnt;
    acc(EFB_K_FETCH, 24'h0, 8'h0);
    `CHK("ext fetch", mem.ext_byte(24'hff0000), d)
    `CHK("ext latency", 5, lat)
    `CHK("bus cycles", c0 + 1, latch_cnt)
    acc(EFB_K_CONST, 24'hff0010, 8'h0);
    `CHK("ext const", mem.ext_byte(24'hff0010), d)
    acc(EFB_K_WRITE, 24'h001234, 8'h9c);
    `CHK("write addr", 24'h001234, wr_addr)
    `CHK("write data", 8'h9c, wr_data)
    acc(EFB_K_READ, 24'h00abcd, 8'h0);
    `CHK("data read", mem.ext_byte(24'h00abcd), d)
    $display("test external done");
    // Ready held low six cycles, first ignored then honoured
    stall_len = 4'(lat + 1);
    acc(EFB_K_FETCH, 24'h0, 8'h0);
    `CHK("no stretch", 5, lat)
    sfr_put(1'b1, 3'h0, 8'h1);
    acc(EFB_K_FETCH, 24'h0, 8'h0);
    `CHK("stretched", 1'b1, lat > 5)
    `CHK("stretch data", mem.ext_byte(24'hff0002), d)
    sfr_put(1'b1, 3'h0, 8'h0);
    stall_len = 4'h0;
    $display("test wait done");
    // Stall clock on and off
    sfr_put(1'b1, 3'h1, 8'h1);
    repeat (2) tick();
    v = stall_clock;
    tick();
    `CHK("stall clock", ~v, stall_clock)
    sfr_put(1'b1, 3'h1, 8'h0);
    repeat (2) tick();
    `CHK("stall clock off", 1'b0, stall_clock)
    $display("test stall clock done");
    // Load the base and the last eight internal bytes, then strap high
    for (i = 0; i < 9; i++) begin
      code_load_addr = (i == 8) ? 15'h0000 : 15'h7ff8 + 15'(i);
      code_load_data = code_load_addr[7:0] ^ 8'hc3;
      code_load_we = 1'b1;
      tick();
    end
    code_load_we = 1'b0;
    do_reset(1'b1);
    c0 = latch_cnt;
    acc(EFB_K_FETCH, 24'h0, 8'h0);
    `CHK("int fetch", 8'hc3, d)
    `CHK("int latency", 3, lat)
    for (i = 0; i < 8; i++) begin
      acc(EFB_K_CONST, 24'hff7ff8 + 24'(i), 8'h0);
      `CHK("tail const", 8'(8'hf8 + i) ^ 8'hc3, d)
    end
    `CHK("quiet bus", c0, latch_cnt)
    jump(24'hff7fff);
    acc(EFB_K_FETCH, 24'h0, 8'h0);
    `CHK("last int", 8'h3c, d)
    acc(EFB_K_FETCH, 24'h0, 8'h0);
    `CHK("prefetch out", mem.ext_byte(24'hff8000), d)
    `CHK("prefetch cycle", c0 + 1, latch_cnt)
    jump(24'hffffff);
    acc(EFB_K_FETCH, 24'h0, 8'h0);
    `CHK("seg end", mem.ext_byte(24'hffffff), d)
    `CHK("wrap pc", 24'hff0000, fetch_pc)
    acc(EFB_K_FETCH, 24'h0, 8'h0);
    `CHK("wrap fetch", 8'hc3, d)
    $display("test internal done");
    print_verdict();
  end
endmodule : tb_efb_fetch_bus
